/* File: hdl/cpgi_consts.svh */
// Register offsets, reset values, field positions and timing counts of the command pulse gear input.
`ifndef CPGI_CONSTS_SVH
`define CPGI_CONSTS_SVH

`define CPGI_ADDR_W 8
`define CPGI_DATA_W 32

`define CPGI_OFF_NUM1 8'h00
`define CPGI_OFF_DENOM 8'h04
`define CPGI_OFF_NUM2 8'h08
`define CPGI_OFF_NUM3 8'h0c
`define CPGI_OFF_NUM4 8'h10
`define CPGI_OFF_FORMAT 8'h14
`define CPGI_OFF_DIR_INV 8'h18
`define CPGI_OFF_POLARITY 8'h1c
`define CPGI_OFF_FILT_LEN 8'h20
`define CPGI_OFF_FILT_SCOPE 8'h24
`define CPGI_OFF_SMOOTH 8'h28
`define CPGI_OFF_GEAR_CMD 8'h2c
`define CPGI_OFF_POS_CMD 8'h30
`define CPGI_OFF_STATUS 8'h34

`define CPGI_GEAR_W 15
`define CPGI_GEAR_MIN 32'h0000_0001
`define CPGI_GEAR_MAX 32'h0000_7fff
`define CPGI_GEAR_RESET 15'h0001
`define CPGI_FORMAT_MAX 32'h0000_0002
`define CPGI_FILT_LEN_MAX 32'h0000_001f
`define CPGI_SMOOTH_MAX 32'h0000_03e8

`define CPGI_POL_PULSE_BIT 0
`define CPGI_POL_SIGN_BIT 1

`define CPGI_CLK_PERIOD_NS 5
`define CPGI_FILTER_STEP_NS 530
`define CPGI_FILTER_STEP_CYCLES ((`CPGI_FILTER_STEP_NS + `CPGI_CLK_PERIOD_NS - 1) / `CPGI_CLK_PERIOD_NS)
`define CPGI_SMOOTH_UNIT_MS 1
`define CPGI_NS_PER_MS 1000000
`define CPGI_CYCLES_PER_MS (`CPGI_SMOOTH_UNIT_MS * `CPGI_NS_PER_MS / `CPGI_CLK_PERIOD_NS)
`define CPGI_SMOOTH_SHIFT 4

`endif

/* File: hdl/cpgi_pkg.sv */
// Types shared by the command pulse gear input.
package cpgi_pkg;
  typedef enum logic [1:0] {
    CPGI_FMT_PULSE_DIR = 2'h0,
    CPGI_FMT_CCW_CW = 2'h1,
    CPGI_FMT_QUAD = 2'h2
  } cpgi_format_t;
  typedef logic signed [31:0] cpgi_pos_t;
endpackage

/* File: hdl/cpgi_line_filter.sv */
// Digital noise filter for one synchronised command line.
`timescale 1ns/1ps
module cpgi_line_filter
  import cpgi_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic line_in,
  input wire logic [CNT_W-1:0] hold_limit,
  output logic line_out
);
  logic [CNT_W-1:0] stable_cnt_reg;
  logic line_reg;

  generate
    if (CNT_W < 12)
    begin : g_check
      $error("cpgi_line_filter: CNT_W too small for the longest filter time");
    end
  endgenerate

  assign line_out = line_reg;

  // A level change is taken only after it has persisted for hold_limit cycles.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_reg <= 1'b0;
      stable_cnt_reg <= '0;
    end
    else if (hold_limit == '0 || line_in == line_reg)
    begin
      line_reg <= line_in;
      stable_cnt_reg <= '0;
    end
    else if (stable_cnt_reg >= hold_limit - 1'b1)
    begin
      line_reg <= line_in;
      stable_cnt_reg <= '0;
    end
    else
    begin
      stable_cnt_reg <= stable_cnt_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_filter_pass: assert property ((hold_limit == '0) |=> (line_out == $past(line_in)))
    else $error("Unfiltered line did not follow its input.");
  a_filter_hold: assert property ((line_out != $past(line_out) && $past(hold_limit) != '0)
    |-> $past(stable_cnt_reg) >= $past(hold_limit) - 1'b1)
    else $error("Filtered line changed before the hold time.");
  c_filter_change: cover property (hold_limit != '0 ##1 line_out != $past(line_out));
endmodule

/* File: hdl/cpgi_top.sv */
// Command pulse input: decoding, polarity, filtering, electronic gear and exponential smoothing.
//
// Contract
// - Each count scaled by numerator over denominator.
// - Denominator 1 to 32767, default one.
// - Numerators two to four, 1..32767, default one.
// - Two select pins choose the active numerator.
// - Format: pulse+direction, CCW/CW pulses, quadrature.
// - Direction setting one reverses counting direction.
// - Polarity setting inverts pulse and/or direction line.
// - Filter length 0..31, 0.53 us per step.
// - Filter zero accepts up to 500 kHz.
// - Filter scope one leaves direction line unfiltered.
// - Exponential smoothing 0..1000 ms, never drops counts.
// - Smoothing time zero passes command undelayed.
`timescale 1ns/1ps
`include "cpgi_consts.svh"
module cpgi_top
  import cpgi_pkg::*;
#(
  parameter int MS_CYCLES = `CPGI_CYCLES_PER_MS,
  parameter int FILT_CNT_W = 12
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pulse_line,
  input wire logic direction_line,
  input wire logic numerator_select_low,
  input wire logic numerator_select_high,
  input wire logic [`CPGI_ADDR_W-1:0] reg_addr,
  input wire logic [`CPGI_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`CPGI_DATA_W-1:0] reg_rdata,
  output cpgi_pos_t position_command
);
  logic [`CPGI_GEAR_W-1:0] numer_reg [4];
  logic [`CPGI_GEAR_W-1:0] gear_denominator_reg;
  logic [1:0] pulse_format_select_reg;
  logic count_direction_invert_reg;
  logic [1:0] line_polarity_select_reg;
  logic [4:0] input_filter_length_reg;
  logic input_filter_scope_reg;
  logic [9:0] position_smoothing_time_reg;
  logic [3:0] pin_meta_reg, pin_sync_reg;
  logic [FILT_CNT_W-1:0] filt_limit;
  logic pulse_pol, sign_pol, pulse_filt, sign_filt, sign_used;
  logic pulse_prev_reg, sign_prev_reg;
  logic count_evt, count_up_raw, count_up;
  logic [`CPGI_GEAR_W-1:0] active_numer;
  cpgi_pos_t residue_reg, residue_sum, residue_next;
  cpgi_pos_t gear_cmd_reg, gear_cmd_next, denom_s;
  cpgi_pos_t smooth_reg, smooth_diff, smooth_delta;
  logic [31:0] tick_cnt_reg, tick_limit;
  logic smooth_tick;
  logic [`CPGI_DATA_W-1:0] rdata_reg;

  generate
    if (MS_CYCLES < 16 || FILT_CNT_W < 12)
    begin : g_check
      $error("cpgi_top: MS_CYCLES must be at least 16 and FILT_CNT_W at least 12");
    end
  endgenerate

  function automatic logic gear_ok(input logic [31:0] v);
    gear_ok = (v >= `CPGI_GEAR_MIN) && (v <= `CPGI_GEAR_MAX);
  endfunction

  // Settings; an out-of-range write is ignored and the old value kept.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        numer_reg[i] <= `CPGI_GEAR_RESET;
      end
      gear_denominator_reg <= `CPGI_GEAR_RESET;
      pulse_format_select_reg <= 2'h0;
      count_direction_invert_reg <= 1'b0;
      line_polarity_select_reg <= 2'h0;
      input_filter_length_reg <= 5'h00;
      input_filter_scope_reg <= 1'b0;
      position_smoothing_time_reg <= 10'h000;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `CPGI_OFF_NUM1: if (gear_ok(reg_wdata)) numer_reg[0] <= reg_wdata[`CPGI_GEAR_W-1:0];
        `CPGI_OFF_NUM2: if (gear_ok(reg_wdata)) numer_reg[1] <= reg_wdata[`CPGI_GEAR_W-1:0];
        `CPGI_OFF_NUM3: if (gear_ok(reg_wdata)) numer_reg[2] <= reg_wdata[`CPGI_GEAR_W-1:0];
        `CPGI_OFF_NUM4: if (gear_ok(reg_wdata)) numer_reg[3] <= reg_wdata[`CPGI_GEAR_W-1:0];
        `CPGI_OFF_DENOM: if (gear_ok(reg_wdata)) gear_denominator_reg <= reg_wdata[`CPGI_GEAR_W-1:0];
        `CPGI_OFF_FORMAT: if (reg_wdata <= `CPGI_FORMAT_MAX) pulse_format_select_reg <= reg_wdata[1:0];
        `CPGI_OFF_DIR_INV: if (reg_wdata[31:1] == '0) count_direction_invert_reg <= reg_wdata[0];
        `CPGI_OFF_POLARITY: if (reg_wdata[31:2] == '0) line_polarity_select_reg <= reg_wdata[1:0];
        `CPGI_OFF_FILT_LEN: if (reg_wdata <= `CPGI_FILT_LEN_MAX) input_filter_length_reg <= reg_wdata[4:0];
        `CPGI_OFF_FILT_SCOPE: if (reg_wdata[31:1] == '0) input_filter_scope_reg <= reg_wdata[0];
        `CPGI_OFF_SMOOTH: if (reg_wdata <= `CPGI_SMOOTH_MAX) position_smoothing_time_reg <= reg_wdata[9:0];
        default:
        begin
        end
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped offsets read zero.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_reg <= '0;
    end
    else if (!reg_read)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      case (reg_addr)
        `CPGI_OFF_NUM1: rdata_reg <= {17'h00000, numer_reg[0]};
        `CPGI_OFF_NUM2: rdata_reg <= {17'h00000, numer_reg[1]};
        `CPGI_OFF_NUM3: rdata_reg <= {17'h00000, numer_reg[2]};
        `CPGI_OFF_NUM4: rdata_reg <= {17'h00000, numer_reg[3]};
        `CPGI_OFF_DENOM: rdata_reg <= {17'h00000, gear_denominator_reg};
        `CPGI_OFF_FORMAT: rdata_reg <= {30'h00000000, pulse_format_select_reg};
        `CPGI_OFF_DIR_INV: rdata_reg <= {31'h00000000, count_direction_invert_reg};
        `CPGI_OFF_POLARITY: rdata_reg <= {30'h00000000, line_polarity_select_reg};
        `CPGI_OFF_FILT_LEN: rdata_reg <= {27'h0000000, input_filter_length_reg};
        `CPGI_OFF_FILT_SCOPE: rdata_reg <= {31'h00000000, input_filter_scope_reg};
        `CPGI_OFF_SMOOTH: rdata_reg <= {22'h000000, position_smoothing_time_reg};
        `CPGI_OFF_GEAR_CMD: rdata_reg <= gear_cmd_reg;
        `CPGI_OFF_POS_CMD: rdata_reg <= smooth_reg;
        `CPGI_OFF_STATUS: rdata_reg <= {26'h0000000, sign_used, pulse_filt, pin_sync_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  // Pins are synchronised: bit 0 pulse, 1 direction, 2 select low, 3 select high.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end
    else
    begin
      pin_meta_reg <= {numerator_select_high, numerator_select_low, direction_line, pulse_line};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign pulse_pol = pin_sync_reg[0] ^ line_polarity_select_reg[`CPGI_POL_PULSE_BIT];
  assign sign_pol = pin_sync_reg[1] ^ line_polarity_select_reg[`CPGI_POL_SIGN_BIT];
  assign filt_limit = FILT_CNT_W'(input_filter_length_reg * `CPGI_FILTER_STEP_CYCLES);

  cpgi_line_filter #(.CNT_W(FILT_CNT_W)) u_pulse_filter (
    .clock(clock),
    .reset_n(reset_n),
    .line_in(pulse_pol),
    .hold_limit(filt_limit),
    .line_out(pulse_filt)
  );

  cpgi_line_filter #(.CNT_W(FILT_CNT_W)) u_sign_filter (
    .clock(clock),
    .reset_n(reset_n),
    .line_in(sign_pol),
    .hold_limit(filt_limit),
    .line_out(sign_filt)
  );

  assign sign_used = input_filter_scope_reg ? sign_pol : sign_filt;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_prev_reg <= 1'b0;
      sign_prev_reg <= 1'b0;
    end
    else
    begin
      pulse_prev_reg <= pulse_filt;
      sign_prev_reg <= sign_used;
    end
  end

  // Edge decoding per line format; direction high or pulse-line phase leading counts up.
  always_comb
  begin
    count_evt = 1'b0;
    count_up_raw = 1'b1;
    case (pulse_format_select_reg)
      CPGI_FMT_PULSE_DIR:
      begin
        count_evt = pulse_filt && !pulse_prev_reg;
        count_up_raw = sign_used;
      end
      CPGI_FMT_CCW_CW:
      begin
        count_evt = (pulse_filt && !pulse_prev_reg) ^ (sign_used && !sign_prev_reg);
        count_up_raw = pulse_filt && !pulse_prev_reg;
      end
      CPGI_FMT_QUAD:
      begin
        count_evt = (pulse_filt ^ pulse_prev_reg) ^ (sign_used ^ sign_prev_reg);
        count_up_raw = pulse_filt ^ sign_prev_reg;
      end
      default:
      begin
      end
    endcase
  end

  assign count_up = count_up_raw ^ count_direction_invert_reg;
  assign active_numer = numer_reg[{pin_sync_reg[3], pin_sync_reg[2]}];
  assign denom_s = cpgi_pos_t'({17'h00000, gear_denominator_reg});

  // Gear: numerator added per count, whole denominators drained as one unit per cycle.
  always_comb
  begin
    residue_sum = residue_reg;
    if (count_evt)
    begin
      residue_sum = count_up ? residue_reg + cpgi_pos_t'({17'h00000, active_numer})
                             : residue_reg - cpgi_pos_t'({17'h00000, active_numer});
    end
    residue_next = residue_sum;
    gear_cmd_next = gear_cmd_reg;
    if (residue_sum >= denom_s)
    begin
      residue_next = residue_sum - denom_s;
      gear_cmd_next = gear_cmd_reg + 32'sh1;
    end
    else if (residue_sum <= -denom_s)
    begin
      residue_next = residue_sum + denom_s;
      gear_cmd_next = gear_cmd_reg - 32'sh1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      residue_reg <= '0;
      gear_cmd_reg <= '0;
    end
    else
    begin
      residue_reg <= residue_next;
      gear_cmd_reg <= gear_cmd_next;
    end
  end

  // Smoothing: every tick the output closes 1/16 of the gap, at least one unit.
  assign tick_limit = (32'(position_smoothing_time_reg) * 32'(MS_CYCLES)) >> `CPGI_SMOOTH_SHIFT;
  assign smooth_tick = (tick_cnt_reg >= tick_limit - 32'h1);
  assign smooth_diff = gear_cmd_next - smooth_reg;

  always_comb
  begin
    smooth_delta = smooth_diff >>> `CPGI_SMOOTH_SHIFT;
    if (smooth_delta == '0 && smooth_diff != '0)
    begin
      smooth_delta = smooth_diff[31] ? -32'sh1 : 32'sh1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt_reg <= '0;
      smooth_reg <= '0;
    end
    else if (position_smoothing_time_reg == 10'h000)
    begin
      tick_cnt_reg <= '0;
      smooth_reg <= gear_cmd_next;
    end
    else if (smooth_tick)
    begin
      tick_cnt_reg <= '0;
      smooth_reg <= smooth_reg + smooth_delta;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  assign position_command = smooth_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_denom_range: assert property (gear_ok({17'h00000, gear_denominator_reg}))
    else $error("Gear denominator out of range.");
  a_numer_range: assert property (gear_ok({17'h00000, numer_reg[1]})
    && gear_ok({17'h00000, numer_reg[2]}) && gear_ok({17'h00000, numer_reg[3]}))
    else $error("Gear numerator out of range.");
  a_numer_select: assert property ((pin_sync_reg[3:2] == 2'h2) |-> (active_numer == numer_reg[2]))
    else $error("Wrong numerator selected.");
  a_format_range: assert property (pulse_format_select_reg != 2'h3)
    else $error("Illegal pulse format held.");
  a_dir_invert: assert property ((count_evt && pulse_format_select_reg == 2'h0)
    |-> (count_up == (sign_used ^ count_direction_invert_reg)))
    else $error("Count direction ignores the invert setting.");
  a_quad_lead: assert property ((pulse_format_select_reg == 2'h2 && pulse_filt && !pulse_prev_reg
    && !sign_used && !sign_prev_reg) |-> (count_evt && count_up_raw))
    else $error("Quadrature leading phase decoded wrongly.");
  a_polarity_map: assert property ((pulse_pol == (pin_sync_reg[0] ^ line_polarity_select_reg[0]))
    && (!input_filter_scope_reg || sign_used == (pin_sync_reg[1] ^ line_polarity_select_reg[1])))
    else $error("Line polarity or filter scope misapplied.");
  a_gear_step: assert property ((residue_sum >= denom_s)
    |=> (gear_cmd_reg == $past(gear_cmd_reg) + 32'sh1) && (residue_reg == $past(residue_sum) - $past(denom_s)))
    else $error("Gear did not emit a unit for a whole denominator.");
  a_smooth_bypass: assert property ((position_smoothing_time_reg == 10'h000)
    |=> (position_command == $past(gear_cmd_next)))
    else $error("Unsmoothed command was delayed.");
  a_smooth_approach: assert property ((position_smoothing_time_reg != 10'h000 && smooth_tick && smooth_diff != '0)
    |=> (position_command != $past(position_command)))
    else $error("Smoothed command stalled with a pending gap.");

  c_quad_count: cover property (pulse_format_select_reg == 2'h2 && count_evt && !count_up);
  c_ccw_cw_count: cover property (pulse_format_select_reg == 2'h1 && count_evt);
  c_gear_down: cover property (residue_sum <= -denom_s);
  c_smooth_tick: cover property (position_smoothing_time_reg != 10'h000 && smooth_tick && smooth_diff != '0);
endmodule

/* File: verif/cpgi_host_model.sv */
// Host motion controller model that drives the two command pulse lines.
`timescale 1ns/1ps
module cpgi_host_model
(
  input wire logic clock,
  output logic pulse_line,
  output logic direction_line
);
  initial
  begin
    pulse_line = 1'b0;
    direction_line = 1'b0;
  end

  // Levels change just after an edge and stand whole cycles, so the synchronisers never see a half level.
  task automatic step(input logic a, input logic b, input int hold);
    @(posedge clock);
    pulse_line <= a;
    direction_line <= b;
    repeat (hold - 1) @(posedge clock);
  endtask

  // The direction level is settled before the first counting edge.
  task automatic pd(input int n, input logic dir, input int hold);
    step(1'b0, dir, hold);
    repeat (n)
    begin
      step(1'b1, dir, hold);
      step(1'b0, dir, hold);
    end
  endtask

  task automatic ccw_cw(input int n, input logic ccw, input int hold);
    repeat (n)
    begin
      step(ccw, !ccw, hold);
      step(1'b0, 1'b0, hold);
    end
  endtask

  // Forward means the pulse line phase leads the direction line phase.
  task automatic quad(input int n, input logic fwd, input int hold);
    repeat (n)
    begin
      step(fwd, !fwd, hold);
      step(1'b1, 1'b1, hold);
      step(!fwd, fwd, hold);
      step(1'b0, 1'b0, hold);
    end
  endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the command pulse gear input.
`timescale 1ns/1ps
`include "cpgi_consts.svh"
module testbench
  import cpgi_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic pulse_line;
  logic direction_line;
  logic numerator_select_low = 1'b0;
  logic numerator_select_high = 1'b0;
  logic [`CPGI_ADDR_W-1:0] reg_addr = 8'h00;
  logic [`CPGI_DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [`CPGI_DATA_W-1:0] reg_rdata;
  cpgi_pos_t position_command;
  cpgi_pos_t exp_pos = 32'sh0;
  int mismatches = 0;
  int cmp_count = 0;

  always #2.5 clock = ~clock;

  cpgi_top #(.MS_CYCLES(1600), .FILT_CNT_W(12)) cpgi_top_i (
    .clock(clock),
    .reset_n(reset_n),
    .pulse_line(pulse_line),
    .direction_line(direction_line),
    .numerator_select_low(numerator_select_low),
    .numerator_select_high(numerator_select_high),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .position_command(position_command)
  );

  cpgi_host_model cpgi_host_model_i (
    .clock(clock),
    .pulse_line(pulse_line),
    .direction_line(direction_line)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] want);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, want);
  endtask

  // Waits a bounded time for the command to reach the expected position, then compares.
  task automatic settle(input int bound);
    int n;
    n = 0;
    #1;
    while (position_command !== exp_pos && n < bound)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (position_command !== exp_pos)
    begin
      mismatches++;
      $display("wait ran out at %0t", $time);
      final_report();
    end
    check(position_command, exp_pos);
  endtask

  task automatic t_defaults();
    for (int i = 0; i < 5; i++)
      rchk(8'(i * 4), 32'h1);
    rchk(`CPGI_OFF_FORMAT, 32'h0);
    rchk(`CPGI_OFF_DIR_INV, 32'h0);
    rchk(`CPGI_OFF_POLARITY, 32'h0);
    rchk(`CPGI_OFF_FILT_LEN, 32'h0);
    rchk(`CPGI_OFF_FILT_SCOPE, 32'h0);
    rchk(`CPGI_OFF_SMOOTH, 32'h0);
    rchk(8'h3c, 32'h0);
    $display("test defaults done");
  endtask

  task automatic t_range();
    wr(`CPGI_OFF_DENOM, 32'h0);
    wr(`CPGI_OFF_DENOM, 32'h8000);
    rchk(`CPGI_OFF_DENOM, 32'h1);
    wr(`CPGI_OFF_NUM4, `CPGI_GEAR_MAX);
    rchk(`CPGI_OFF_NUM4, `CPGI_GEAR_MAX);
    wr(`CPGI_OFF_FORMAT, 32'h3);
    rchk(`CPGI_OFF_FORMAT, 32'h0);
    wr(`CPGI_OFF_POS_CMD, 32'h5);
    rchk(`CPGI_OFF_POS_CMD, 32'h0);
    $display("test ranges done");
  endtask

  task automatic t_gear();
    wr(`CPGI_OFF_NUM1, 32'h3);
    wr(`CPGI_OFF_DENOM, 32'h2);
    cpgi_host_model_i.pd(4, 1'b1, 8);
    exp_pos += 6;
    settle(400);
    cpgi_host_model_i.pd(4, 1'b0, 8);
    exp_pos -= 6;
    settle(400);
    wr(`CPGI_OFF_NUM1, 32'h1);
    wr(`CPGI_OFF_DENOM, 32'h1);
    $display("test gear done");
  endtask

  task automatic t_select();
    wr(`CPGI_OFF_NUM2, 32'h2);
    wr(`CPGI_OFF_NUM3, 32'h3);
    wr(`CPGI_OFF_NUM4, 32'h4);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clock);
      numerator_select_low <= s[0];
      numerator_select_high <= s[1];
      cpgi_host_model_i.pd(1, 1'b1, 8);
      exp_pos += s + 1;
      settle(400);
    end
    @(posedge clock);
    numerator_select_low <= 1'b0;
    numerator_select_high <= 1'b0;
    $display("test select done");
  endtask

  task automatic t_formats();
    cpgi_host_model_i.step(1'b0, 1'b0, 8);
    wr(`CPGI_OFF_FORMAT, 32'h1);
    cpgi_host_model_i.ccw_cw(2, 1'b1, 8);
    exp_pos += 2;
    settle(400);
    cpgi_host_model_i.ccw_cw(3, 1'b0, 8);
    exp_pos -= 3;
    settle(400);
    wr(`CPGI_OFF_FORMAT, 32'h2);
    cpgi_host_model_i.quad(2, 1'b1, 8);
    exp_pos += 8;
    settle(400);
    cpgi_host_model_i.quad(1, 1'b0, 8);
    exp_pos -= 4;
    settle(400);
    wr(`CPGI_OFF_DIR_INV, 32'h1);
    cpgi_host_model_i.quad(1, 1'b1, 8);
    exp_pos -= 4;
    settle(400);
    wr(`CPGI_OFF_DIR_INV, 32'h0);
    wr(`CPGI_OFF_FORMAT, 32'h0);
    wr(`CPGI_OFF_POLARITY, 32'h2);
    cpgi_host_model_i.pd(2, 1'b1, 8);
    exp_pos -= 2;
    settle(400);
    wr(`CPGI_OFF_POLARITY, 32'h0);
    $display("test formats done");
  endtask

  // Direction falls 20 cycles after the pulse rises, so only an unfiltered direction line is seen in time.
  task automatic late_dir(input logic scope, input int delta);
    wr(`CPGI_OFF_FILT_SCOPE, {31'h0, scope});
    cpgi_host_model_i.step(1'b0, 1'b1, 150);
    cpgi_host_model_i.step(1'b1, 1'b1, 20);
    cpgi_host_model_i.step(1'b1, 1'b0, 150);
    cpgi_host_model_i.step(1'b0, 1'b0, 150);
    exp_pos += delta;
    settle(400);
  endtask

  task automatic t_filter();
    wr(`CPGI_OFF_FILT_LEN, 32'h1);
    cpgi_host_model_i.pd(1, 1'b1, 20);
    settle(400);
    cpgi_host_model_i.pd(1, 1'b1, 150);
    exp_pos += 1;
    settle(400);
    late_dir(1'b0, 1);
    late_dir(1'b1, -1);
    wr(`CPGI_OFF_FILT_SCOPE, 32'h0);
    wr(`CPGI_OFF_FILT_LEN, 32'h0);
    cpgi_host_model_i.pd(3, 1'b1, 3);
    exp_pos += 3;
    settle(400);
    $display("test filter done");
  endtask

  task automatic t_smooth();
    wr(`CPGI_OFF_SMOOTH, 32'h1);
    cpgi_host_model_i.pd(4, 1'b1, 8);
    exp_pos += 4;
    #1;
    check({31'h0, position_command === exp_pos}, 32'h0);
    rchk(`CPGI_OFF_GEAR_CMD, exp_pos);
    settle(1000);
    wr(`CPGI_OFF_SMOOTH, 32'h0);
    cpgi_host_model_i.pd(1, 1'b1, 8);
    exp_pos += 1;
    settle(12);
    $display("test smoothing done");
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_defaults();
    t_range();
    t_gear();
    t_select();
    t_formats();
    t_filter();
    t_smooth();
    final_report();
  end
endmodule
